//--- hw/drr_pkg.sv
// Shared constants, types and decoders for the row repair sequencer
package drr_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0]  REG_CTRL    = 5'h00;
    localparam logic [4:0]  REG_WLAT    = 5'h04;
    localparam logic [4:0]  REG_POSTW   = 5'h08;
    localparam logic [4:0]  REG_STATUS  = 5'h0C;
    localparam logic [4:0]  REG_FUSE    = 5'h10;
    localparam logic [4:0]  REG_ROW0    = 5'h14;
    localparam logic [4:0]  REG_ROW1    = 5'h18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_LOW_IGN_BIT = 0;
    localparam int          CTRL_X16_BIT     = 1;
    localparam logic        RST_LOW_IGN      = 1'b0;
    localparam logic        RST_X16          = 1'b1;
    localparam logic [4:0]  RST_WLAT         = 5'h0C;
    localparam logic [15:0] RST_POSTW        = 16'h0010;
    localparam int          MR4_HARD_BIT     = 13;
    localparam int          MR4_SOFT_BIT     = 5;
    localparam int          AP_BIT           = 10;
    localparam int          MPR_HARD_BIT     = 7;
    localparam int          MPR_SOFT_BIT     = 6;
    localparam logic [2:0]  MR_SEL_MR0       = 3'h0;
    localparam logic [2:0]  MR_SEL_MR4       = 3'h4;
    localparam logic [6:0]  KEY_LOW_ONES     = 7'h7F;
    localparam logic [15:0] DQ_ALL_HIGH      = 16'hFFFF;
    localparam logic [15:0] DQ_ALL_LOW       = 16'h0000;
    localparam logic [7:0]  KEEP_ALL_BANKS   = 8'hFF;

    // Guard key address bits 11..7, index 0 arrives first (listed last step first)
    localparam logic [3:0][4:0] GUARD_KEY = {5'h07, 5'h17, 5'h0F, 5'h19};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_DES, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD,
        CMD_OTHER
    } drr_cmd_e;

    typedef enum logic [3:0] {
        ST_IDLE, ST_KEY, ST_ABORT, ST_ARMED, ST_ROW, ST_WLAT, ST_DATA,
        ST_PROG, ST_POST
    } drr_st_e;

    typedef enum logic [1:0] {
        OUT_NONE, OUT_COMMIT, OUT_SKIP, OUT_UNDEF
    } drr_out_e;

    // ------------------------------------------------------------
    // Command decode from chip select, activate and A16..A14
    // ------------------------------------------------------------
    function automatic drr_cmd_e drr_decode(input logic cs_n,
                                            input logic act_n,
                                            input logic [2:0] rcw);
        drr_cmd_e c;
        c = CMD_OTHER;
        if (cs_n) begin
            c = CMD_DES;
        end else if (!act_n) begin
            c = CMD_ACT;
        end else begin
            unique case (rcw)
                3'b000:  c = CMD_MRS;
                3'b001:  c = CMD_REF;
                3'b010:  c = CMD_PRE;
                3'b100:  c = CMD_WR;
                3'b101:  c = CMD_RD;
                default: c = CMD_OTHER;
            endcase
        end
        return c;
    endfunction

endpackage

//--- hw/drr_link_sampler.sv
// Link pin synchroniser and command clock edge sampler
module drr_link_sampler
    import drr_pkg::*;
(
    // System
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Link pins
    input  wire logic        i_ck,
    input  wire logic        i_cs_n,
    input  wire logic        i_act_n,
    input  wire logic [17:0] i_addr,
    input  wire logic [1:0]  i_bg,
    input  wire logic [1:0]  i_ba,
    input  wire logic [15:0] i_dq,
    // Sampled command
    output logic             o_rise,
    output logic             o_cs_n,
    output logic             o_act_n,
    output logic [17:0]      o_addr,
    output logic [1:0]       o_bg,
    output logic [1:0]       o_ba,
    output logic [15:0]      o_dq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        ck_s1;
        logic        ck_s2;
        logic        ck_s3;
        logic [39:0] pin_s1;
        logic [39:0] pin_s2;
        logic        rise;
        logic [39:0] cap;
    } drr_smp_s;

    drr_smp_s smp_ff;
    drr_smp_s nxt_smp;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_smp        = smp_ff;
        // First stages feed only the second stages
        nxt_smp.ck_s1  = i_ck;
        nxt_smp.ck_s2  = smp_ff.ck_s1;
        nxt_smp.ck_s3  = smp_ff.ck_s2;
        nxt_smp.pin_s1 = {i_cs_n, i_act_n, i_addr, i_bg, i_ba, i_dq};
        nxt_smp.pin_s2 = smp_ff.pin_s1;
        nxt_smp.rise   = smp_ff.ck_s2 & ~smp_ff.ck_s3;
        if (smp_ff.ck_s2 & ~smp_ff.ck_s3) begin
            nxt_smp.cap = smp_ff.pin_s2;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            smp_ff <= '0;
        end else begin
            smp_ff <= nxt_smp;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rise  = smp_ff.rise;
    assign o_cs_n  = smp_ff.cap[39];
    assign o_act_n = smp_ff.cap[38];
    assign o_addr  = smp_ff.cap[37:20];
    assign o_bg    = smp_ff.cap[19:18];
    assign o_ba    = smp_ff.cap[17:16];
    assign o_dq    = smp_ff.cap[15:0];

endmodule

//--- hw/drr_repair_seq.sv
// Device-side post package row repair sequencer with register slave
//
// Behaviour
// - Soft repair entered by MR4 bit 5 with the same key.
// - Key: BG/BA zero, A11..A7 fixed per step, A6..A0 all ones.
// - Low key bits optionally ignored; BG1 ignored on x16 parts.
// - Bad key: no repair, no hang, ACT and WR act normally.
// - No error indication for a wrong key sequence.
// - Activate failing row then write; write column ignored.
// - Four low data beats commit; first two high skip repair.
// - Commands accepted again after post repair wait elapses.
// - Refresh in repair keeps all banks but the target bank and its BA1 pair partner.
// - One row per bank group; fuses are one-time.
// - Page two reports hard support bit 7, soft bit 6.
module drr_repair_seq
    import drr_pkg::*;
#(
    parameter logic HARD_SUPPORTED = 1'b1,
    parameter logic SOFT_SUPPORTED = 1'b1
)(
    // System
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Link pins
    input  wire logic        i_ck,
    input  wire logic        i_cs_n,
    input  wire logic        i_act_n,
    input  wire logic [17:0] i_addr,
    input  wire logic [1:0]  i_bg,
    input  wire logic [1:0]  i_ba,
    input  wire logic [15:0] i_dq,
    // Core side
    output logic             o_cmd_ready,
    output logic             o_access,
    output logic             o_ref,
    output logic [7:0]       o_ref_keep,
    output logic [7:0]       o_mpr_page2,
    // Avalon-MM slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);

    // ------------------------------------------------------------
    // Sampled link
    // ------------------------------------------------------------
    logic        rise;
    logic        cs_n;
    logic        act_n;
    logic [17:0] addr;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [15:0] dq;

    drr_link_sampler u_smp (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ck    (i_ck),
        .i_cs_n  (i_cs_n),
        .i_act_n (i_act_n),
        .i_addr  (i_addr),
        .i_bg    (i_bg),
        .i_ba    (i_ba),
        .i_dq    (i_dq),
        .o_rise  (rise),
        .o_cs_n  (cs_n),
        .o_act_n (act_n),
        .o_addr  (addr),
        .o_bg    (bg),
        .o_ba    (ba),
        .o_dq    (dq)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        drr_st_e          st;
        logic             hard_mode;
        logic             mr4_hard;
        logic             mr4_soft;
        logic [4:0]       cnt;
        logic [1:0]       beat;
        logic             all_low;
        logic             first_high;
        logic             tgt_bg;
        logic [1:0]       tgt_ba;
        logic [17:0]      tgt_row;
        logic             ap;
        logic [1:0]       hard_used;
        logic [1:0]       soft_used;
        logic [1:0][19:0] hard_row;
        drr_out_e         outcome;
        logic [15:0]      post_cnt;
        logic             ready;
        logic             ref_p;
        logic [7:0]       keep;
        logic             access;
        logic             low_ign;
        logic             x16;
        logic [4:0]       wlat;
        logic [15:0]      postw;
        logic             ack;
        logic [31:0]      rdata;
    } drr_seq_s;

    drr_seq_s seq_ff;
    drr_seq_s nxt_seq;

    // ------------------------------------------------------------
    // Guard key match
    // ------------------------------------------------------------
    function automatic logic key_ok(input logic [1:0]  idx,
                                    input logic [17:0] a,
                                    input logic [1:0]  g,
                                    input logic [1:0]  b,
                                    input logic        low_ign,
                                    input logic        x16);
        logic ok;
        ok = ({g[0], b} == MR_SEL_MR0) && (x16 || !g[1]);
        ok = ok && (a[11:7] == GUARD_KEY[idx]);
        ok = ok && (low_ign || (a[6:0] == KEY_LOW_ONES));
        return ok;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    drr_cmd_e cmd;
    logic     is_mr4;
    logic     leave;
    logic     enter;
    logic     avail;
    logic     req;
    logic     in_tgt;

    always_comb begin
        nxt_seq        = seq_ff;
        nxt_seq.ref_p  = 1'b0;
        nxt_seq.access = 1'b0;
        cmd    = drr_decode(cs_n, act_n, addr[16:14]);
        is_mr4 = rise && (cmd == CMD_MRS) && ({bg[0], ba} == MR_SEL_MR4);
        leave  = is_mr4 && (seq_ff.hard_mode ? !addr[MR4_HARD_BIT]
                                             : !addr[MR4_SOFT_BIT]);
        // A set bit must first be cleared before a new entry
        enter  = is_mr4 && ((addr[MR4_HARD_BIT] && !seq_ff.mr4_hard) ||
                            (addr[MR4_SOFT_BIT] && !seq_ff.mr4_soft));
        avail  = seq_ff.hard_mode
               ? !seq_ff.hard_used[bg[0]] && !seq_ff.soft_used[bg[0]]
               : !seq_ff.hard_used[bg[0]] && !seq_ff.soft_used[bg[0]];
        in_tgt = (seq_ff.st == ST_ROW) || (seq_ff.st == ST_WLAT) ||
                 (seq_ff.st == ST_DATA) || (seq_ff.st == ST_PROG);

        if (is_mr4) begin
            nxt_seq.mr4_hard = addr[MR4_HARD_BIT];
            nxt_seq.mr4_soft = addr[MR4_SOFT_BIT];
        end

        if (rise && (cmd == CMD_REF)) begin
            nxt_seq.ref_p = 1'b1;
            nxt_seq.keep  = KEEP_ALL_BANKS;
            if (in_tgt) begin
                nxt_seq.keep[{seq_ff.tgt_bg, seq_ff.tgt_ba[1], 1'b0}] = 1'b0;
                nxt_seq.keep[{seq_ff.tgt_bg, seq_ff.tgt_ba[1], 1'b1}] = 1'b0;
            end
        end

        if (rise) begin
            unique case (seq_ff.st)
                ST_IDLE: begin
                    if (enter) begin
                        nxt_seq.st        = ST_KEY;
                        nxt_seq.cnt       = '0;
                        nxt_seq.hard_mode = addr[MR4_HARD_BIT];
                    end else if (cmd == CMD_ACT || cmd == CMD_WR) begin
                        nxt_seq.access = 1'b1;
                    end
                end
                ST_KEY: begin
                    if (cmd != CMD_DES) begin
                        if (cmd == CMD_MRS &&
                            key_ok(seq_ff.cnt[1:0], addr, bg, ba,
                                   seq_ff.low_ign, seq_ff.x16)) begin
                            nxt_seq.cnt = seq_ff.cnt + 5'h01;
                            if (seq_ff.cnt[1:0] == 2'h3) begin
                                nxt_seq.st = ST_ARMED;
                            end
                        end else begin
                            nxt_seq.st = leave ? ST_IDLE : ST_ABORT;
                        end
                    end
                end
                ST_ABORT: begin
                    if (leave) begin
                        nxt_seq.st = ST_IDLE;
                    end else if (cmd == CMD_ACT || cmd == CMD_WR) begin
                        nxt_seq.access = 1'b1;
                    end
                end
                ST_ARMED: begin
                    if (leave) begin
                        nxt_seq.st = ST_IDLE;
                    end else if (cmd == CMD_ACT) begin
                        nxt_seq.tgt_bg  = bg[0];
                        nxt_seq.tgt_ba  = ba;
                        nxt_seq.tgt_row = addr;
                        nxt_seq.st      = avail ? ST_ROW : ST_ABORT;
                    end
                end
                ST_ROW: begin
                    if (leave) begin
                        nxt_seq.st = ST_IDLE;
                    end else if (cmd == CMD_WR) begin
                        nxt_seq.ap  = addr[AP_BIT];
                        nxt_seq.cnt = seq_ff.wlat;
                        nxt_seq.st  = ST_WLAT;
                    end
                end
                ST_WLAT: begin
                    if (seq_ff.cnt <= 5'h01) begin
                        nxt_seq.all_low    = (dq == DQ_ALL_LOW);
                        nxt_seq.first_high = (dq == DQ_ALL_HIGH);
                        nxt_seq.beat       = 2'h1;
                        nxt_seq.st         = ST_DATA;
                    end else begin
                        nxt_seq.cnt = seq_ff.cnt - 5'h01;
                    end
                end
                ST_DATA: begin
                    nxt_seq.all_low = seq_ff.all_low && (dq == DQ_ALL_LOW);
                    if (seq_ff.beat == 2'h1) begin
                        nxt_seq.first_high = seq_ff.first_high &&
                                             (dq == DQ_ALL_HIGH);
                    end
                    nxt_seq.beat = seq_ff.beat + 2'h1;
                    if (seq_ff.beat == 2'h3) begin
                        nxt_seq.st = ST_PROG;
                        if (seq_ff.all_low && (dq == DQ_ALL_LOW)) begin
                            nxt_seq.outcome = OUT_COMMIT;
                            if (seq_ff.hard_mode) begin
                                nxt_seq.hard_used[seq_ff.tgt_bg] = 1'b1;
                                nxt_seq.hard_row[seq_ff.tgt_bg] =
                                    {seq_ff.tgt_ba, seq_ff.tgt_row};
                            end else begin
                                nxt_seq.soft_used[seq_ff.tgt_bg] = 1'b1;
                            end
                        end else if (seq_ff.first_high) begin
                            nxt_seq.outcome = OUT_SKIP;
                        end else begin
                            nxt_seq.outcome = OUT_UNDEF;
                        end
                    end
                end
                ST_PROG: begin
                    if (leave) begin
                        nxt_seq.st       = ST_POST;
                        nxt_seq.post_cnt = seq_ff.postw;
                        nxt_seq.ready    = 1'b0;
                    end
                end
                ST_POST: begin
                    if (seq_ff.post_cnt <= 16'h0001) begin
                        nxt_seq.st    = ST_IDLE;
                        nxt_seq.ready = 1'b1;
                    end else begin
                        nxt_seq.post_cnt = seq_ff.post_cnt - 16'h0001;
                    end
                end
            endcase
        end

        // Register slave: one wait cycle, then the answer
        req         = i_avs_read || i_avs_write;
        nxt_seq.ack = req && !seq_ff.ack;
        if (req && !seq_ff.ack && i_avs_read) begin
            unique case (i_avs_address)
                REG_CTRL:   nxt_seq.rdata = {30'h0000_0000, seq_ff.x16,
                                             seq_ff.low_ign};
                REG_WLAT:   nxt_seq.rdata = {27'h000_0000, seq_ff.wlat};
                REG_POSTW:  nxt_seq.rdata = {16'h0000, seq_ff.postw};
                REG_STATUS: nxt_seq.rdata = {23'h00_0000, seq_ff.ready,
                                             seq_ff.outcome,
                                             seq_ff.mr4_soft,
                                             seq_ff.mr4_hard,
                                             4'(seq_ff.st)};
                REG_FUSE:   nxt_seq.rdata = {27'h000_0000, seq_ff.ap,
                                             seq_ff.soft_used,
                                             seq_ff.hard_used};
                REG_ROW0:   nxt_seq.rdata = {12'h000, seq_ff.hard_row[0]};
                REG_ROW1:   nxt_seq.rdata = {12'h000, seq_ff.hard_row[1]};
                default:    nxt_seq.rdata = 32'h0000_0000;
            endcase
        end
        if (seq_ff.ack && i_avs_write) begin
            unique case (i_avs_address)
                REG_CTRL: begin
                    nxt_seq.low_ign = i_avs_writedata[CTRL_LOW_IGN_BIT];
                    nxt_seq.x16     = i_avs_writedata[CTRL_X16_BIT];
                end
                REG_WLAT:  nxt_seq.wlat  = i_avs_writedata[4:0];
                REG_POSTW: nxt_seq.postw = i_avs_writedata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            seq_ff         <= '0;
            seq_ff.st      <= ST_IDLE;
            seq_ff.outcome <= OUT_NONE;
            seq_ff.ready   <= 1'b1;
            seq_ff.keep    <= KEEP_ALL_BANKS;
            seq_ff.low_ign <= RST_LOW_IGN;
            seq_ff.x16     <= RST_X16;
            seq_ff.wlat    <= RST_WLAT;
            seq_ff.postw   <= RST_POSTW;
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_cmd_ready       = seq_ff.ready;
    assign o_access          = seq_ff.access;
    assign o_ref             = seq_ff.ref_p;
    assign o_ref_keep        = seq_ff.keep;
    assign o_avs_readdata    = seq_ff.rdata;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !seq_ff.ack;

    always_comb begin
        o_mpr_page2               = 8'h00;
        o_mpr_page2[MPR_HARD_BIT] = HARD_SUPPORTED;
        o_mpr_page2[MPR_SOFT_BIT] = SOFT_SUPPORTED;
    end

endmodule

//--- dv/drr_repair_seq_properties.sv
// Port checker for the row repair sequencer
module drr_repair_seq_properties
    import drr_pkg::*;
#(
    parameter logic HARD_SUPPORTED = 1'b1,
    parameter logic SOFT_SUPPORTED = 1'b1
)(
    // System and bus
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_avs_read,
    input wire logic       i_avs_write,
    input wire logic       o_avs_waitrequest,
    // Core side
    input wire logic       o_cmd_ready,
    input wire logic       o_access,
    input wire logic       o_ref,
    input wire logic [7:0] o_ref_keep,
    input wire logic [7:0] o_mpr_page2
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire req = i_avs_read | i_avs_write;
    AST_MPR: assert property (
        o_mpr_page2[7:6] == {HARD_SUPPORTED, SOFT_SUPPORTED})
        else $error("support flags wrong");
    AST_KEEP_PAIR: assert property (o_ref |-> o_ref_keep == 8'hFF ||
        (~o_ref_keep) inside {8'h03, 8'h0C, 8'h30, 8'hC0})
        else $error("keep mask not a bank pair");
    AST_KEEP_HOLD: assert property (!o_ref |-> $stable(o_ref_keep))
        else $error("keep mask moved without refresh");
    AST_ACC_PULSE: assert property (o_access |=> !o_access [*8])
        else $error("access pulse too long");
    AST_REF_PULSE: assert property (o_ref |=> !o_ref [*8])
        else $error("refresh pulse too long");
    // Bounded so a stuck post wait is seen
    AST_READY: assert property ($fell(o_cmd_ready) |-> ##[1:400] o_cmd_ready)
        else $error("ready never returned");
    AST_WAIT_ONE: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer late");
    AST_WAIT_NEW: assert property ($rose(req) |-> o_avs_waitrequest)
        else $error("bus answer early");
endmodule

bind drr_repair_seq drr_repair_seq_properties #(
    .HARD_SUPPORTED(HARD_SUPPORTED),
    .SOFT_SUPPORTED(SOFT_SUPPORTED)
) u_props (.i_clk, .i_rst, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
    .o_cmd_ready, .o_access, .o_ref, .o_ref_keep, .o_mpr_page2);

//--- dv/drr_ctl_model.sv
// Controller model driving the command link pins
module drr_ctl_model (
    // Link pins
    output logic        o_ck,
    output logic        o_cs_n,
    output logic        o_act_n,
    output logic [17:0] o_addr,
    output logic [1:0]  o_bg,
    output logic [1:0]  o_ba,
    output logic [15:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_ck, o_cs_n, o_act_n} = 3'h3;
        {o_addr, o_bg, o_ba, o_dq} = '1;
    end
    task automatic send(input logic s, input logic n, input logic [17:0] a,
                        input logic [1:0] g, input logic [1:0] b,
                        input logic [15:0] d);
        #4;
        {o_cs_n, o_act_n, o_addr, o_bg, o_ba, o_dq} = {s, n, a, g, b, d};
        #28 o_ck = 1'b1;
        #32 o_ck = 1'b0;
        // Released lines flip so stale values never look valid
        {o_addr, o_bg, o_ba, o_dq} = ~{a, g, b, d};
        {o_cs_n, o_act_n} = 2'h3;
    endtask
endmodule

//--- dv/tb_drr_repair_seq.sv
// Testbench for the row repair sequencer
module tb_drr_repair_seq
    import drr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rd, wr, ck, cs_n, act_n, rdy, acc, rf, wq;
    logic [17:0] addr;
    logic [1:0]  bg, ba;
    logic [15:0] dq;
    logic [4:0]  adr;
    logic [31:0] wd, q, rdat;
    logic [7:0]  keep, mpr;
    int          errors, comparisons, n_acc, n_ref, n0;
    always #2.5 clk = ~clk;
    drr_ctl_model u_ctl (.o_ck(ck), .o_cs_n(cs_n), .o_act_n(act_n),
        .o_addr(addr), .o_bg(bg), .o_ba(ba), .o_dq(dq));
    drr_repair_seq u_dut (.i_clk(clk), .i_rst(rst), .i_ck(ck),
        .i_cs_n(cs_n), .i_act_n(act_n), .i_addr(addr), .i_bg(bg),
        .i_ba(ba), .i_dq(dq), .o_cmd_ready(rdy), .o_access(acc),
        .o_ref(rf), .o_ref_keep(keep), .o_mpr_page2(mpr),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata(q), .o_avs_waitrequest(wq));
    always @(posedge clk) begin
        n_acc += int'(acc === 1'b1);
        n_ref += int'(rf === 1'b1);
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {wr, rd, adr, wd} <= {w, !w, a, d};
        // Waitrequest judged at the rising edge, answer taken there
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 20);
        if (wq !== 1'b0) begin
            errors++;
            stop_test;
        end
        rdat = q;
        {wr, rd} <= 2'h0;
    endtask
    task automatic rchk(input string nm, input logic [4:0] a,
                        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    task automatic cmd(input logic [17:0] a, input logic [1:0] g,
                       input logic [1:0] b, input logic n = 1'b1);
        u_ctl.send(1'b0, n, a, g, b, 16'hFFFF);
    endtask
    task automatic des(input int k, input logic [15:0] d);
        repeat (k) u_ctl.send(1'b1, 1'b1, 18'h0, 2'h0, 2'h0, d);
    endtask
    task automatic key(input int last);
        for (int i = 0; i <= last; i++)
            cmd({6'h00, GUARD_KEY[i], KEY_LOW_ONES}, 2'h0, 2'h0);
    endtask
    initial begin
        {rd, wr, adr, wd} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("mpr", 32'h3, 32'(mpr[7:6]));
        rchk("ctrl", REG_CTRL, 32'h2);
        rchk("wlat", REG_WLAT, 32'hC);
        rchk("postw", REG_POSTW, 32'h10);
        rchk("hole", 5'h1C, 32'h0);
        bus(1'b1, REG_WLAT, 32'h2);
        bus(1'b1, REG_POSTW, 32'h4);
        bus(1'b1, REG_STATUS, 32'hFFFF_FFFF);
        rchk("stat", REG_STATUS, 32'h100);
        cmd(18'h0_2000, 2'h1, 2'h0);
        key(3);
        cmd(18'h0_1234, 2'h1, 2'h2, 1'b0);
        cmd(18'h1_0400, 2'h1, 2'h2);
        des(1, 16'hFFFF);
        des(4, 16'h0);
        cmd(18'h0_4000, 2'h0, 2'h0);
        cmd(18'h0_8000, 2'h1, 2'h2);
        cmd(18'h0, 2'h1, 2'h0);
        repeat (4) @(posedge clk);
        chk("busy", 32'h0, 32'(rdy));
        des(5, 16'h0);
        repeat (8) @(posedge clk);
        chk("ready", 32'h1, 32'(rdy));
        chk("refs", 32'h1, n_ref);
        chk("keep", 32'h3F, 32'(keep));
        rchk("fuse", REG_FUSE, 32'h12);
        rchk("row1", REG_ROW1, 32'h0008_1234);
        rchk("stat", REG_STATUS, 32'h140);
        // second sequence from mode bit onward
        n0 = n_acc;
        cmd(18'h0_2000, 2'h1, 2'h0);
        key(0);
        cmd({6'h00, GUARD_KEY[2], KEY_LOW_ONES}, 2'h0, 2'h0);
        cmd(18'h0_0100, 2'h0, 2'h0, 1'b0);
        cmd(18'h1_0000, 2'h0, 2'h0);
        repeat (8) @(posedge clk);
        chk("acc", n0 + 2, n_acc);
        chk("alive", 32'h1, 32'(rdy));
        cmd(18'h0, 2'h1, 2'h0);
        cmd(18'h0_0020, 2'h1, 2'h0);
        key(3);
        cmd(18'h0_0055, 2'h0, 2'h1, 1'b0);
        cmd(18'h1_0000, 2'h0, 2'h1);
        des(3, 16'hFFFF);
        des(2, 16'h0);
        repeat (8) @(posedge clk);
        rchk("fuse", REG_FUSE, 32'h2);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("outcome", 32'h2, 32'(rdat[7:6]));
        stop_test;
    end
endmodule
